/* src/ilc_indicator.sv */
`timescale 1ns/100ps
module ilc_indicator #(
	parameter int BLINK_MS0 = ilc_pkg::ILC_BLINK_MS0,
	parameter int BLINK_MS1 = ilc_pkg::ILC_BLINK_MS1,
	parameter int BLINK_MS2 = ilc_pkg::ILC_BLINK_MS2,
	parameter int BLINK_MS3 = ilc_pkg::ILC_BLINK_MS3,
	parameter int MS_CYC    = ilc_pkg::ILC_MS_CYC
) (
	input  wire logic                 sys_clk,            // 250 MHz
	input  wire logic                 reset,              // sync, high
	input  wire logic [31:0]          s_axi_awaddr,       // write address
	input  wire logic                 s_axi_awvalid,      // write addr valid
	output logic                      s_axi_awready,      // write addr ready
	input  wire logic [31:0]          s_axi_wdata,        // write data
	input  wire logic [3:0]           s_axi_wstrb,        // byte enables
	input  wire logic                 s_axi_wvalid,       // write data valid
	output logic                      s_axi_wready,       // write data ready
	output logic [1:0]                s_axi_bresp,        // write response
	output logic                      s_axi_bvalid,       // write resp valid
	input  wire logic                 s_axi_bready,       // write resp ready
	input  wire logic [31:0]          s_axi_araddr,       // read address
	input  wire logic                 s_axi_arvalid,      // read addr valid
	output logic                      s_axi_arready,      // read addr ready
	output logic [31:0]               s_axi_rdata,        // read data
	output logic [1:0]                s_axi_rresp,        // read response
	output logic                      s_axi_rvalid,       // read data valid
	input  wire logic                 s_axi_rready,       // read data ready
	input  wire ilc_pkg::ilc_phy_st_t phy_st,             // phy status, same clock
	input  wire logic                 mgmt1_read,         // pulse: mgmt reg 1 read
	output logic                      indicator_out_a,    // indicator a
	output logic                      indicator_out_b,    // indicator b
	output logic                      indicator_out_c,    // indicator c
	output logic [3:0]                termination_setting // rx pin termination
);
	import ilc_pkg::*;

	logic [15:0] src_cfg_q;
	logic [15:0] term_q;
	logic        aw_held_q, w_held_q;
	logic [31:0] awaddr_q, wdata_q;
	logic [3:0]  wstrb_q;
	logic        link_lost_q, link_prev_q, prbs_q;
	logic [31:0] blink_cnt_q;
	logic        blink_q;
	logic [31:0] blink_lim;
	logic        do_write, unmapped_w;
	logic [2:0]  ind_q;

	// write channel: address and data accepted independently
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;
	assign unmapped_w    = awaddr_q != ILC_ADDR_SRC_CFG && awaddr_q != ILC_ADDR_TERM;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 32'h0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			else if (do_write)
				aw_held_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			else if (do_write)
				w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= unmapped_w ? 2'h2 : 2'h0;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	function automatic logic [15:0] ilc_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0])
			r[7:0] = d[7:0];
		if (be[1])
			r[15:8] = d[15:8];
		return r;
	endfunction : ilc_merge

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			src_cfg_q <= ILC_SRC_CFG_RST;
			term_q    <= ILC_TERM_RST;
		end
		else if (do_write)
		begin
			if (awaddr_q == ILC_ADDR_SRC_CFG)
				src_cfg_q <= ilc_merge(src_cfg_q, wdata_q, wstrb_q);
			if (awaddr_q == ILC_ADDR_TERM)
				term_q <= ilc_merge(term_q, wdata_q, wstrb_q);
		end
	end

	assign termination_setting = term_q[ILC_TERM_LSB +: 4];

	// read channel: one-cycle answer after address taken
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case (s_axi_araddr)
				ILC_ADDR_SRC_CFG: s_axi_rdata <= {16'h0, src_cfg_q};
				ILC_ADDR_TERM:    s_axi_rdata <= {16'h0, term_q};
				ILC_ADDR_STATUS:  s_axi_rdata <= {26'h0, blink_q, prbs_q, link_lost_q, ind_q};
				default:
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// sticky event flags; the set wins over the clear
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			link_prev_q <= 1'b0;
			link_lost_q <= 1'b0;
			prbs_q      <= 1'b0;
		end
		else
		begin
			link_prev_q <= phy_st.link_up;
			if (link_prev_q && !phy_st.link_up)
				link_lost_q <= 1'b1;
			else if (mgmt1_read)
				link_lost_q <= 1'b0;
			if (phy_st.prbs_err)
				prbs_q <= 1'b1;
			else if (phy_st.prbs_clr)
				prbs_q <= 1'b0;
		end
	end

	// blink timer: one toggle per half period, so a full on/off cycle matches the rate;
	// a shorter period wraps at once, a longer one extends the running count
	always_comb
	begin
		case (src_cfg_q[ILC_RATE_LSB +: 2])
			2'h0:    blink_lim = 32'(BLINK_MS0 * MS_CYC / 2);
			2'h1:    blink_lim = 32'(BLINK_MS1 * MS_CYC / 2);
			2'h2:    blink_lim = 32'(BLINK_MS2 * MS_CYC / 2);
			default: blink_lim = 32'(BLINK_MS3 * MS_CYC / 2);
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			blink_cnt_q <= 32'h0;
			blink_q     <= 1'b0;
		end
		else if (blink_cnt_q >= blink_lim - 32'h1)
		begin
			blink_cnt_q <= 32'h0;
			blink_q     <= !blink_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 32'h1;
	end

	function automatic logic ilc_src(input logic [3:0] sel, input ilc_phy_st_t st,
		input logic blink, input logic lost, input logic perr);
		logic act;
		act = st.tx_act || st.rx_act;
		case (sel)
			ILC_SEL_LINK:      ilc_src = st.link_up;
			ILC_SEL_LINK_ACT:  ilc_src = st.link_up && !(act && blink);
			ILC_SEL_LINK_TX:   ilc_src = st.link_up && !(st.tx_act && blink);
			ILC_SEL_LINK_MST:  ilc_src = st.link_up && st.is_master;
			ILC_SEL_LINK_SLV:  ilc_src = st.link_up && !st.is_master;
			ILC_SEL_ACT:       ilc_src = act && blink;
			ILC_SEL_LINK_LOST: ilc_src = lost;
			ILC_SEL_PRBS:      ilc_src = perr;
			default:           ilc_src = 1'b0;
		endcase
	endfunction : ilc_src

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			ind_q <= 3'h0;
		else
		begin
			ind_q[0] <= ilc_src(src_cfg_q[ILC_SEL0_LSB +: 4], phy_st, blink_q,
				link_lost_q, prbs_q);
			ind_q[1] <= ilc_src(src_cfg_q[ILC_SEL1_LSB +: 4], phy_st, blink_q,
				link_lost_q, prbs_q);
			ind_q[2] <= ilc_src(src_cfg_q[ILC_SEL2_LSB +: 4], phy_st, blink_q,
				link_lost_q, prbs_q);
		end
	end

	assign indicator_out_a = ind_q[0];
	assign indicator_out_b = ind_q[1];
	assign indicator_out_c = ind_q[2];

	a_lost_sticky: assert property (@(posedge sys_clk) disable iff (reset)
		link_lost_q && !mgmt1_read && !(link_prev_q && !phy_st.link_up) |=> link_lost_q)
		else $error("link lost flag dropped without read");
	a_lost_set: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(phy_st.link_up) |-> ##1 link_lost_q)
		else $error("link loss not captured");
	a_prbs_hold: assert property (@(posedge sys_clk) disable iff (reset)
		prbs_q && !phy_st.prbs_clr |=> prbs_q)
		else $error("prbs flag dropped without clear");
	a_term_out: assert property (@(posedge sys_clk) disable iff (reset)
		do_write && awaddr_q == ILC_ADDR_TERM && wstrb_q[0]
		|=> termination_setting == $past(wdata_q[4:1]))
		else $error("termination field not stored");
	a_link_only: assert property (@(posedge sys_clk) disable iff (reset)
		src_cfg_q[3:0] == 4'h0 && $stable(src_cfg_q) |=> indicator_out_a == $past(phy_st.link_up))
		else $error("link-only source wrong");
	a_role_mst: assert property (@(posedge sys_clk) disable iff (reset)
		src_cfg_q[7:4] == 4'h4 && $stable(src_cfg_q)
		|=> indicator_out_b == $past(phy_st.link_up && phy_st.is_master))
		else $error("master role source wrong");
	a_reserved_dark: assert property (@(posedge sys_clk) disable iff (reset)
		src_cfg_q[11:8] == 4'h7 && $stable(src_cfg_q) |=> !indicator_out_c)
		else $error("reserved code lit output");
	a_blink_wrap: assert property (@(posedge sys_clk) disable iff (reset)
		blink_cnt_q >= blink_lim - 32'h1 |=> blink_q != $past(blink_q) && blink_cnt_q == 0)
		else $error("blink toggle missing");
	a_rate_reset: assert property (@(posedge sys_clk)
		$past(reset) && !reset |-> src_cfg_q[13:12] == 2'b10 && src_cfg_q[11:8] == 4'h6)
		else $error("config reset value wrong");
	a_read_one: assert property (@(posedge sys_clk) disable iff (reset)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_resp: assert property (@(posedge sys_clk) disable iff (reset)
		do_write |=> s_axi_bvalid)
		else $error("write answer missing");
	a_lost_clear: assert property (@(posedge sys_clk) disable iff (reset)
		mgmt1_read && !(link_prev_q && !phy_st.link_up) |=> !link_lost_q)
		else $error("link lost flag not cleared by read");
	a_role_slv: assert property (@(posedge sys_clk) disable iff (reset)
		src_cfg_q[11:8] == ILC_SEL_LINK_SLV && $stable(src_cfg_q)
		|=> indicator_out_c == $past(phy_st.link_up && !phy_st.is_master))
		else $error("slave role source wrong");

	// one error pulse is enough to light the prbs source
	sequence s_prbs_hit;
		phy_st.prbs_err;
	endsequence
	a_prbs_set: assert property (@(posedge sys_clk) disable iff (reset)
		s_prbs_hit |=> prbs_q)
		else $error("prbs error not captured");

endmodule : ilc_indicator

/* src/ilc_pkg.sv */
package ilc_pkg;

	// printed offsets are register indices (not multiples of four)
	localparam logic [15:0] ILC_IDX_SRC_CFG  = 16'h0460;
	localparam logic [15:0] ILC_IDX_TERM     = 16'h0461;
	localparam logic [31:0] ILC_ADDR_SRC_CFG = 32'h0000_1180;
	localparam logic [31:0] ILC_ADDR_TERM    = 32'h0000_1184;
	// own choice: status register for the block state
	localparam logic [31:0] ILC_ADDR_STATUS  = 32'h0000_1188;
	localparam logic [31:0] ILC_ADDR_MGMT1   = 32'h0000_0004;

	localparam logic [15:0] ILC_SRC_CFG_RST  = 16'h2610;
	localparam logic [15:0] ILC_TERM_RST     = 16'h0410;

	localparam int ILC_RATE_LSB = 12;
	localparam int ILC_SEL2_LSB = 8;
	localparam int ILC_SEL1_LSB = 4;
	localparam int ILC_SEL0_LSB = 0;
	localparam int ILC_TERM_LSB = 1;

	localparam int ILC_CLK_MHZ   = 250;
	localparam int ILC_BLINK_MS0 = 50;
	localparam int ILC_BLINK_MS1 = 100;
	localparam int ILC_BLINK_MS2 = 200;
	localparam int ILC_BLINK_MS3 = 500;
	localparam int ILC_MS_CYC    = ILC_CLK_MHZ * 1000;

	localparam logic [3:0] ILC_SEL_LINK      = 4'h0;
	localparam logic [3:0] ILC_SEL_LINK_ACT  = 4'h1;
	localparam logic [3:0] ILC_SEL_LINK_TX   = 4'h2;
	localparam logic [3:0] ILC_SEL_LINK_MST  = 4'h4;
	localparam logic [3:0] ILC_SEL_LINK_SLV  = 4'h5;
	localparam logic [3:0] ILC_SEL_ACT       = 4'h6;
	localparam logic [3:0] ILC_SEL_LINK_LOST = 4'h9;
	localparam logic [3:0] ILC_SEL_PRBS      = 4'ha;

	typedef struct packed {
		logic link_up;
		logic is_master;
		logic tx_act;
		logic rx_act;
		logic prbs_err;
		logic prbs_clr;
	} ilc_phy_st_t;

endpackage : ilc_pkg

/* verif/ilc_phy_model.sv */
`timescale 1ns/100ps
module ilc_phy_model (
	input  wire logic                 sys_clk,   // bench clock
	input  wire ilc_pkg::ilc_phy_st_t cmd,       // wanted status
	input  wire logic                 rd_cmd,    // mgmt read request
	output ilc_pkg::ilc_phy_st_t      phy_st,    // to block
	output logic                      mgmt1_read // read pulse
);
	import ilc_pkg::*;
	int seed = 32'hcd51;
	// rx activity gets noise only while tx is commanded high, so the activity state stays certain
	always_ff @(posedge sys_clk)
	begin
		phy_st <= ilc_phy_st_t'(cmd | {3'b000, cmd.tx_act & ($random(seed) % 2 != 0), 2'b00});
		mgmt1_read <= rd_cmd;
	end
endmodule : ilc_phy_model

/* verif/indicator_led_config_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end
module indicator_led_config_tb;
	import ilc_pkg::*;
	logic        sys_clk = 0, reset = 1, rd_cmd = 0, p;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, a_o, b_o, c_o, mgmt1_read;
	logic [1:0]  bresp, rresp;
	logic [3:0]  term, strb = 4'hf;
	logic [15:0] v;
	logic [33:0] e_m, g_m, exp_q[$], msk_q[$];
	ilc_phy_st_t cmd = '0, phy_st;
	int          error_cnt = 0, samples_checked = 0, seed = 32'hcd51, n, ms, q;
	localparam int          SIM_MS = 4;
	localparam logic [15:0] CFG[6] = '{16'h0540, 16'h0540, 16'h0621, 16'h0621, 16'h07b8, 16'h0540};
	localparam logic [5:0]  ST[6]  = '{6'h30, 6'h20, 6'h20, 6'h00, 6'h38, 6'h00};
	localparam logic [2:0]  EXP[6] = '{3'b011, 3'b101, 3'b011, 3'b000, 3'b000, 3'b000};

	always #2 sys_clk = ~sys_clk;

	ilc_indicator #(.MS_CYC(SIM_MS)) dut_u (.sys_clk(sys_clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.phy_st(phy_st), .mgmt1_read(mgmt1_read), .indicator_out_a(a_o),
		.indicator_out_b(b_o), .indicator_out_c(c_o), .termination_setting(term));
	ilc_phy_model pm_u (.sys_clk(sys_clk), .cmd(cmd), .rd_cmd(rd_cmd), .phy_st(phy_st),
		.mgmt1_read(mgmt1_read));

	// one transfer at a time, so the shared queues exp_q and msk_q pair answers with notes
	always @(posedge sys_clk)
		if ((rvalid && rready) || (bvalid && bready))
		begin
			e_m = exp_q.pop_front();
			g_m = (rvalid ? {rresp, rdata} : {bresp, 32'h0}) & msk_q.pop_front();
			`CHK(g_m, e_m)
		end

	task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] r);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= {16'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		exp_q.push_back({r, 32'h0});
		msk_q.push_back('1);
		do
		begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [33:0] e, input logic [33:0] m);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		do
		begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
	endtask : rd

	task automatic st(input logic [2:0] e);
		repeat (3) @(posedge sys_clk);
		rd(ILC_ADDR_STATUS, {31'h0, e}, 34'h3_0000_0007);
		`CHK({c_o, b_o, a_o}, e)
	endtask : st

	task automatic pulse(input logic [5:0] s);
		@(posedge sys_clk);
		cmd <= s;
		@(posedge sys_clk);
		cmd <= '0;
	endtask : pulse

	task automatic mrd();
		@(posedge sys_clk);
		rd_cmd <= 1'b1;
		@(posedge sys_clk);
		rd_cmd <= 1'b0;
	endtask : mrd

	task automatic end_sim();
		if (error_cnt == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		end_sim();
	end

	initial
	begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		`CHK(term, 4'b1000)
		rd(ILC_ADDR_SRC_CFG, 34'h2610, '1);
		rd(ILC_ADDR_TERM, 34'h0410, '1);
		rd(32'h0000_1200, {2'b10, 32'h0}, '1);
		wr(32'h0000_1200, 16'h1234, 2'b10);
		v = 16'($random(seed));
		wr(ILC_ADDR_TERM, v, 2'b00);
		rd(ILC_ADDR_TERM, {18'h0, v}, '1);
		`CHK(term, v[4:1])
		strb <= 4'h1;
		wr(ILC_ADDR_TERM, ~v, 2'b00);
		strb <= 4'hf;
		rd(ILC_ADDR_TERM, {18'h0, v[15:8], ~v[7:0]}, '1);
		`CHK(term, ~v[4:1])
		for (int i = 0; i < 6; i++)
		begin
			wr(ILC_ADDR_SRC_CFG, CFG[i], 2'b00);
			cmd <= ST[i];
			st(EXP[i]);
		end
		wr(ILC_ADDR_SRC_CFG, 16'h0009, 2'b00);
		mrd();
		st(3'b000);
		pulse(6'h20);
		st(3'b001);
		mrd();
		st(3'b000);
		wr(ILC_ADDR_SRC_CFG, 16'h000a, 2'b00);
		st(3'b000);
		pulse(6'h02);
		st(3'b001);
		pulse(6'h01);
		st(3'b000);
		pulse(6'h03);
		st(3'b001);
		for (int r = 0; r < 2; r++)
		begin
			wr(ILC_ADDR_SRC_CFG, r ? 16'h3600 : 16'h0600, 2'b00);
			cmd <= 6'h28;
			ms = r ? ILC_BLINK_MS3 : ILC_BLINK_MS0;
			q = 2400 / (ms * SIM_MS);
			n = 0;
			repeat (1200)
			begin
				p = c_o;
				@(posedge sys_clk);
				if (c_o !== p) n++;
			end
			`CHK(n + 1 >= q && n <= q + 1 && n > 0, 1'b1)
		end
		end_sim();
	end
endmodule : indicator_led_config_tb
